// [core/otp_pkg.sv]
// shared constants and types for the otp program and hardware lock block
package otp_pkg;

    // command opcodes seen on the link
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PROGRAM_OTP = 8'h9B;

    // status byte one bit positions
    localparam int ST_LOCK = 7;
    localparam int ST_ERROR = 5;
    localparam int ST_WP_PIN = 4;
    localparam int ST_PROTECT = 2;
    localparam int ST_WEL = 1;
    localparam int ST_BUSY = 0;

    // sizes of the secure area and the shared buffer
    localparam int USER_BYTES = 64;
    localparam int OTP_BYTES = 128;
    localparam int BUF_BYTES = 256;
    localparam int USER_AW = 6;
    localparam int BUF_AW = 8;

    // byte positions within a frame, counted in whole bytes
    localparam logic [2:0] IDX_OPCODE = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [2:0] CNT_FULL = 3'h5;
    localparam logic [6:0] DATA_FULL = 7'h40;

    // reset and erased values
    localparam logic BPL_RESET = 1'b0;
    localparam logic BP0_RESET = 1'b0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // secure_area_program_time, longest time, so cycles round down
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS = 200000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

    // summary of a finished frame, held still on the link side
    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] byteCnt;
        logic [2:0] bitCnt;
        logic [6:0] dataCnt;
        logic [5:0] offset;
        logic [7:0] statusData;
        logic toggle;
    } otp_frame_t;

    // programming sequencer states
    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_READ = 2'b01,
        PS_WRITE = 2'b10,
        PS_WAIT = 2'b11
    } otp_state_t;

endpackage

// [core/otp_dual_mem.sv]
// small two-clock memory with registered read data
`timescale 1ns/1ns
module otp_dual_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter logic [7:0] INIT = 8'hFF
) (
    // write side
    input wire logic wrClk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read side
    input wire logic rdClk,
    input wire logic rdReset_n,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    // cells start erased; no reset, so contents survive a reset pulse
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = WIDTH'(INIT);
        end
    end

    // write port; plain always since the initial block also loads mem
    always @(posedge wrClk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge rdClk or negedge rdReset_n) begin
        if (!rdReset_n) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// [core/otp_program_lock.sv]
// hardware lock of block protection and secure area programming
// Function
// [R1] hardware lock active only with write-protect pin asserted and lock bit 1
// [R2] while locked, both protect bits frozen and write-status ignored
// [R3] host deasserts write-protect then clears lock bit to unlock
// [R4] with pin asserted a set lock bit clears only by power-up reset
// [R5] pin deasserted: lock bit may be set, array-protect stays writable
// [R6] lock bit 0 to 1 always allowed, 1 to 0 only with pin deasserted
// [R7] secure area 128 bytes: 0..63 user once, 64..127 factory value
// [R8] factory upper half is never altered by any command
// [R9] user half programmed once as a unit, no erase; later attempts refused; code refuses them only until reset_n clears otpDone_q
// [R10] host sets write enable, then sends 9Bh, three address bytes, data
// [R11] only address bits 5..0 select the user byte
// [R12] data running past byte 63 wraps to offset zero
// [R13] more than 64 data bytes keeps only the last 64
// [R14] program at frame end by offset and count; unsent bytes stay FFh
// [R15] three address bytes, one data byte, byte-aligned end, else abort
// [R16] aborted program clears the write-enable latch
// [R17] busy during program cycle; write-enable latch cleared before its end
// [R18] host should poll status instead of waiting the longest time
// [R19] program command uses and overwrites the shared 256-byte buffer
// [R20] program cycle self-timed without link clocking
// [R21] write enable set by 06h with byte-aligned frame end
// [R22] status bit 7 lock, bit 2 array-protect; only these writable
// [R23] program-error flag refreshed after every program operation
// [R24] write-protect pin synchronised before lock decisions
// [R25] once-programmed flag set as soon as a program cycle starts
`timescale 1ns/1ns
module otp_program_lock #(
    parameter int PROG_CYCLES = otp_pkg::PROG_CYCLES,
    // arbitrary per-device factory value
    parameter logic [511:0] FACTORY_ID = {64{8'hA5}}
) (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // serial link
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    // write-protect pin, active low
    input wire logic wpN,
    // secure area read port
    input wire logic [6:0] otpRdAddr,
    output logic [7:0] otpRdData,
    // status
    output logic [7:0] statusByte,
    output logic hwLocked,
    output logic userProgrammed
);

    // ---------------- link domain ----------------
    logic freshFrame_q;
    logic [2:0] bitCnt_q;
    logic [2:0] byteCnt_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic [5:0] offset_q;
    logic [5:0] slot_q;
    logic [6:0] dataCnt_q;
    logic [7:0] statusData_q;
    logic toggle_q;
    logic [2:0] bitNow;
    logic [2:0] byteNow;
    logic [6:0] dataNow;
    logic [7:0] newByte;
    logic byteDone;
    logic bufWrEn;

    // set while chip select is high so the next frame starts from zero;
    // counters are not cleared here so the core can still read them
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            freshFrame_q <= 1'b1;
        end else begin
            freshFrame_q <= 1'b0;
        end
    end

    // effective counts for the current edge
    always_comb begin
        bitNow = freshFrame_q ? 3'h0 : bitCnt_q;
        byteNow = freshFrame_q ? 3'h0 : byteCnt_q;
        dataNow = freshFrame_q ? 7'h00 : dataCnt_q;
        newByte = {shift_q[6:0], mosi};
        byteDone = (bitNow == 3'h7);
        bufWrEn = byteDone && (byteNow >= otp_pkg::IDX_DATA) &&
                  (opcode_q == otp_pkg::OP_PROGRAM_OTP); // [R10] [R19]
    end

    // bit and byte framing, byte count saturates at 5, one past the first data byte
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_q <= 3'h0;
            byteCnt_q <= 3'h0;
            shift_q <= 8'h00;
        end else begin
            bitCnt_q <= bitNow + 3'h1;
            shift_q <= newByte;
            if (byteDone && byteNow != otp_pkg::CNT_FULL) begin
                byteCnt_q <= byteNow + 3'h1;
            end else begin
                byteCnt_q <= byteNow;
            end
        end
    end

    // frame marker toggles once per frame that saw a clock edge
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            toggle_q <= 1'b0;
        end else if (freshFrame_q) begin
            toggle_q <= ~toggle_q;
        end
    end

    // opcode, status data and start offset capture
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            opcode_q <= 8'h00;
            statusData_q <= 8'h00;
            offset_q <= 6'h00;
        end else if (byteDone) begin
            if (byteNow == otp_pkg::IDX_OPCODE) begin
                opcode_q <= newByte;
            end
            if (byteNow == otp_pkg::IDX_STATUS) begin
                statusData_q <= newByte;
            end
            if (byteNow == otp_pkg::IDX_ADDR_LAST) begin
                offset_q <= newByte[5:0]; // upper address ignored [R11]
            end
        end
    end

    // buffer slot pointer wraps in the 64-byte space, count saturates
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            slot_q <= 6'h00;
            dataCnt_q <= 7'h00;
        end else begin
            if (byteDone && byteNow == otp_pkg::IDX_ADDR_LAST) begin
                slot_q <= newByte[5:0];
            end else if (bufWrEn) begin
                slot_q <= slot_q + 6'h01; // wrap to offset zero [R12]
            end
            if (bufWrEn && dataNow != otp_pkg::DATA_FULL) begin
                dataCnt_q <= dataNow + 7'h01;
            end else begin
                dataCnt_q <= dataNow; // last 64 overwrite older ones [R13]
            end
        end
    end

    // ---------------- core domain ----------------
    otp_pkg::otp_frame_t frame;
    otp_pkg::otp_state_t state_q;
    logic csMeta_q;
    logic csSync_q;
    logic csPrev_q;
    logic wpMeta_q;
    logic wpSync_q;
    logic lastToggle_q;
    logic wel_q;
    logic bpl_q;
    logic bp0_q;
    logic epe_q;
    logic errAcc_q;
    logic otpDone_q;
    logic busy;
    logic frameEnd;
    logic cmdOk;
    logic wsGo;
    logic progGo;
    logic progAbort;
    logic locked;
    logic [6:0] progIdx_q;
    logic [19:0] waitCnt_q;
    logic [5:0] rel;
    logic inRange;
    logic [7:0] bufRd;
    logic [7:0] otpRd;
    logic [5:0] otpAddr;
    logic otpWrEn;
    logic [7:0] otpWrData;
    logic selFactory_q;
    logic [5:0] factIdx_q;

    // link registers are quiet once chip select is high and no clock runs
    assign frame = '{opcode: opcode_q, byteCnt: byteCnt_q,
                     bitCnt: bitCnt_q, dataCnt: dataCnt_q,
                     offset: offset_q, statusData: statusData_q,
                     toggle: toggle_q};

    // two-stage synchronisers for chip select and write protect
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            csPrev_q <= 1'b1;
            wpMeta_q <= 1'b0;
            wpSync_q <= 1'b0;
        end else begin
            csMeta_q <= csN;
            csSync_q <= csMeta_q;
            csPrev_q <= csSync_q;
            wpMeta_q <= wpN; // [R24]
            wpSync_q <= wpMeta_q; // [R24]
        end
    end

    // frame end decode; a frame with no clock edge leaves toggle unchanged
    always_comb begin
        busy = (state_q != otp_pkg::PS_IDLE);
        locked = !wpSync_q && bpl_q; // [R1]
        frameEnd = csSync_q && !csPrev_q && !busy;
        cmdOk = frameEnd && (frame.toggle != lastToggle_q) &&
                (frame.bitCnt == 3'h0) &&
                (frame.byteCnt != otp_pkg::IDX_OPCODE); // [R21]
        wsGo = cmdOk && (frame.opcode == otp_pkg::OP_WRITE_STATUS) &&
               wel_q && (frame.byteCnt > otp_pkg::IDX_STATUS) &&
               !locked; // [R2]
        progGo = cmdOk && (frame.opcode == otp_pkg::OP_PROGRAM_OTP) &&
                 wel_q && (frame.byteCnt == otp_pkg::CNT_FULL) &&
                 !otpDone_q; // [R9] [R15]
        progAbort = frameEnd && !progGo && wel_q &&
                    (frame.toggle != lastToggle_q) &&
                    (frame.opcode == otp_pkg::OP_PROGRAM_OTP) &&
                    (frame.byteCnt != otp_pkg::IDX_OPCODE); // [R16]
    end

    // remember the last frame seen, even one dropped while busy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lastToggle_q <= 1'b0;
        end else if (csSync_q && !csPrev_q) begin
            lastToggle_q <= frame.toggle;
        end
    end

    // write-enable latch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wel_q <= 1'b0;
        end else if (progGo || progAbort) begin
            wel_q <= 1'b0; // cleared at cycle start [R16] [R17]
        end else if (cmdOk && frame.opcode == otp_pkg::OP_WRITE_ENABLE) begin
            wel_q <= 1'b1; // [R21]
        end else if (cmdOk && frame.opcode == otp_pkg::OP_WRITE_DISABLE) begin
            wel_q <= 1'b0;
        end else if (wsGo) begin
            wel_q <= 1'b0;
        end
    end

    // protection bits; only bits 7 and 2 of the data are used
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bpl_q <= otp_pkg::BPL_RESET; // power-up clears lock [R4]
            bp0_q <= otp_pkg::BP0_RESET;
        end else if (wsGo) begin
            bp0_q <= frame.statusData[otp_pkg::ST_PROTECT]; // [R5] [R22]
            if (frame.statusData[otp_pkg::ST_LOCK] || wpSync_q) begin
                bpl_q <= frame.statusData[otp_pkg::ST_LOCK]; // [R6] [R22]
            end
        end
    end

    // once-programmed flag set at start; reset_n clears it, so a cycle cut by reset does not block
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            otpDone_q <= 1'b0;
        end else if (progGo) begin
            otpDone_q <= 1'b1; // [R25]
        end
    end

    // user byte programmed only if it lies in the sent window
    always_comb begin
        rel = progIdx_q[5:0] - frame.offset;
        inRange = (frame.dataCnt == otp_pkg::DATA_FULL) ||
                  ({1'b0, rel} < frame.dataCnt); // [R14]
        otpWrEn = (state_q == otp_pkg::PS_WRITE) && inRange;
        otpWrData = otpRd & bufRd; // cells only move toward zero
        otpAddr = busy ? progIdx_q[5:0] : otpRdAddr[5:0];
    end

    // self-timed sequencer: walk 64 user bytes, then wait out the time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= otp_pkg::PS_IDLE;
            progIdx_q <= 7'h00;
        end else begin
            case (state_q)
                otp_pkg::PS_IDLE: begin
                    progIdx_q <= 7'h00;
                    if (progGo) begin
                        state_q <= otp_pkg::PS_READ; // [R20]
                    end
                end
                otp_pkg::PS_READ: begin
                    state_q <= otp_pkg::PS_WRITE;
                end
                otp_pkg::PS_WRITE: begin
                    progIdx_q <= progIdx_q + 7'h01;
                    if (progIdx_q == 7'(otp_pkg::USER_BYTES - 1)) begin
                        state_q <= otp_pkg::PS_WAIT;
                    end else begin
                        state_q <= otp_pkg::PS_READ;
                    end
                end
                otp_pkg::PS_WAIT: begin
                    if (waitCnt_q >= 20'(PROG_CYCLES - 1)) begin
                        state_q <= otp_pkg::PS_IDLE;
                    end
                end
                default: begin
                    state_q <= otp_pkg::PS_IDLE;
                end
            endcase
        end
    end

    // cycle timer counts from start of the program cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitCnt_q <= 20'h00000;
        end else if (!busy) begin
            waitCnt_q <= 20'h00000;
        end else begin
            waitCnt_q <= waitCnt_q + 20'h00001; // [R20]
        end
    end

    // error tracking, refreshed when the cycle ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            errAcc_q <= 1'b0;
            epe_q <= 1'b0;
        end else if (progGo) begin
            errAcc_q <= 1'b0;
        end else if (otpWrEn && otpWrData != bufRd) begin
            errAcc_q <= 1'b1; // a bit that would need to rise
        end else if (state_q == otp_pkg::PS_WAIT &&
                     waitCnt_q >= 20'(PROG_CYCLES - 1)) begin
            epe_q <= errAcc_q; // [R23]
        end
    end

    // shared buffer: written from the link, read by the sequencer
    otp_dual_mem #(
        .WIDTH(8),
        .DEPTH(otp_pkg::BUF_BYTES),
        .AW(otp_pkg::BUF_AW),
        .INIT(otp_pkg::ERASED_BYTE)
    ) u_buffer (
        .wrClk(sck),
        .wrEn(bufWrEn),
        .wrAddr({2'b00, slot_q}), // [R19]
        .wrData(newByte),
        .rdClk(clk),
        .rdReset_n(reset_n),
        .rdAddr({2'b00, progIdx_q[5:0]}),
        .rdData(bufRd)
    );

    // user half only; the factory half lives in a constant [R7] [R8]
    otp_dual_mem #(
        .WIDTH(8),
        .DEPTH(otp_pkg::USER_BYTES),
        .AW(otp_pkg::USER_AW),
        .INIT(otp_pkg::ERASED_BYTE)
    ) u_user_area (
        .wrClk(clk),
        .wrEn(otpWrEn),
        .wrAddr(progIdx_q[5:0]),
        .wrData(otpWrData),
        .rdClk(clk),
        .rdReset_n(reset_n),
        .rdAddr(otpAddr),
        .rdData(otpRd)
    );

    // read port: two cycles of latency, user-half reads are undefined while busy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            selFactory_q <= 1'b0;
            factIdx_q <= 6'h00;
            otpRdData <= 8'h00;
        end else begin
            selFactory_q <= otpRdAddr[6];
            factIdx_q <= otpRdAddr[5:0];
            if (selFactory_q) begin
                otpRdData <= FACTORY_ID[{factIdx_q, 3'b000} +: 8]; // [R8]
            end else begin
                otpRdData <= otpRd;
            end
        end
    end

    // registered status view
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            statusByte <= 8'h00;
            hwLocked <= 1'b0;
            userProgrammed <= 1'b0;
        end else begin
            statusByte <= {bpl_q, 1'b0, epe_q, wpSync_q,
                           1'b0, bp0_q, wel_q, busy}; // [R17] [R22]
            hwLocked <= locked; // [R1]
            userProgrammed <= otpDone_q;
        end
    end

endmodule

// [dv/otp_program_lock_properties.sv]
// port-level assertions for the otp program and hardware lock block
`timescale 1ns/1ns
module otp_program_lock_properties #(
    parameter int PROG_CYCLES = otp_pkg::PROG_CYCLES,
    parameter logic [511:0] FACTORY_ID = {64{8'hA5}}
) (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // pin and read port
    input wire logic wpN,
    input wire logic [6:0] otpRdAddr,
    input wire logic [7:0] otpRdData,
    // status
    input wire logic [7:0] statusByte,
    input wire logic hwLocked,
    input wire logic userProgrammed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic busy;
    logic [15:0] busyCnt_q;
    logic [6:0] addr1_q;
    logic [6:0] addr2_q;
    assign busy = statusByte[otp_pkg::ST_BUSY];

    // length of the current busy stretch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt_q <= 16'h0000;
        end else if (busy) begin
            busyCnt_q <= busyCnt_q + 16'h0001;
        end else begin
            busyCnt_q <= 16'h0000;
        end
    end

    // read address lined up with the registered read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr1_q <= 7'h00;
            addr2_q <= 7'h00;
        end else begin
            addr1_q <= otpRdAddr;
            addr2_q <= addr1_q;
        end
    end

    sequence s_prog_start;
        $rose(busy);
    endsequence
    sequence s_read_idle;
        !busy [*3];
    endsequence

    a_lock_needs_pin: assert property (wpN [*5] |-> !hwLocked)
        else $error("lock active with pin deasserted");
    a_locked_frozen: assert property (hwLocked [*2] |->
        $stable(statusByte[7]) && $stable(statusByte[2]))
        else $error("protect bits changed while locked");
    a_lock_held_low: assert property (
        statusByte[7] && !statusByte[4] |=> statusByte[7])
        else $error("lock bit cleared with pin asserted");
    a_busy_drops_wel: assert property (
        $fell(busy) |-> !statusByte[otp_pkg::ST_WEL])
        else $error("write enable still set after program");
    a_prog_time_bound: assert property (
        busyCnt_q <= PROG_CYCLES + 8)
        else $error("program cycle too long");
    a_prog_marks_once: assert property (
        s_prog_start |-> ##[0:2] userProgrammed)
        else $error("once flag not set at program start");
    a_no_reprogram: assert property (
        s_prog_start |-> !$past(userProgrammed, 3))
        else $error("second program cycle started");
    a_factory_fixed: assert property (s_read_idle ##0 addr2_q[6] |->
        otpRdData == FACTORY_ID[addr2_q[5:0] * 8 +: 8])
        else $error("factory byte altered");
    a_reserved_zero: assert property (
        !statusByte[6] && !statusByte[3] &&
        hwLocked == (statusByte[7] && !statusByte[4]))
        else $error("reserved status bit set");
    a_pin_synced: assert property (
        wpN [*4] |-> statusByte[otp_pkg::ST_WP_PIN])
        else $error("pin status not following pin");
endmodule

bind otp_program_lock otp_program_lock_properties #(
    .PROG_CYCLES(PROG_CYCLES),
    .FACTORY_ID(FACTORY_ID)
) u_props (
    .clk(clk),
    .reset_n(reset_n),
    .wpN(wpN),
    .otpRdAddr(otpRdAddr),
    .otpRdData(otpRdData),
    .statusByte(statusByte),
    .hwLocked(hwLocked),
    .userProgrammed(userProgrammed)
);

// [dv/otp_spi_host.sv]
// link-side host model sending command frames
`timescale 1ns/1ns
module otp_spi_host (
    // serial link
    output logic sck,
    output logic csN,
    output logic mosi
);
    // idle: clock parked low, chip select high
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end

    // one frame msb first; may stop off a byte boundary
    task automatic send(input logic [7:0] q[$], input int bits);
        #7;
        csN = 1'b0;
        for (int i = 0; i < bits; i++) begin
            mosi = q[i / 8][7 - i % 8];
            #15 sck = 1'b1;
            #15 sck = 1'b0;
        end
        #15 csN = 1'b1;
        mosi = ~mosi; // released line shows no stale value
    endtask
endmodule

// [dv/otp_program_and_hw_lock_test.sv]
// self-checking bench for the otp program and hardware lock block
`timescale 1ns/1ns
module otp_program_and_hw_lock_test;
    localparam int PROG = 200;
    // arbitrary factory value
    localparam logic [511:0] FID = {64{8'h3C}};
    logic clk, reset_n, wpN, sck, csN, mosi, hwLocked, userProgrammed;
    logic [6:0] otpRdAddr;
    logic [7:0] otpRdData, statusByte, gotV, ev;
    logic [7:0] expQ[$], q[$], dat[66];
    int mismatches, tests_run, seed, n;
    event seen;

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
    mismatches++; $display("CHECK FAILED at %0t got %h exp %h", \
    $time, a, e); end end

    otp_spi_host host (.sck(sck), .csN(csN), .mosi(mosi));
    otp_program_lock #(.PROG_CYCLES(PROG), .FACTORY_ID(FID)) uut (
        .clk(clk), .reset_n(reset_n), .sck(sck), .csN(csN), .mosi(mosi),
        .wpN(wpN), .otpRdAddr(otpRdAddr), .otpRdData(otpRdData),
        .statusByte(statusByte), .hwLocked(hwLocked),
        .userProgrammed(userProgrammed));

    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // scoreboard: oldest note against each observed result
    always @(seen) begin
        ev = expQ.pop_front();
        `CHK(gotV, ev)
    end

    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task note(input logic [7:0] act, input logic [7:0] exp);
        expQ.push_back(exp);
        gotV = act;
        ->seen;
        #1;
    endtask
    task st(input logic act, input logic exp);
        note({7'h00, act}, {7'h00, exp});
    endtask
    // frame then room for decode and the gap between frames
    task frame(input int bits);
        host.send(q, bits);
        cyc(8);
    endtask
    task write_enable_latch();
        q = '{otp_pkg::OP_WRITE_ENABLE};
        frame(8);
    endtask
    task wrst(input logic [7:0] v);
        write_enable_latch();
        q = '{otp_pkg::OP_WRITE_STATUS, v};
        frame(16);
    endtask
    task rd(input logic [6:0] a, input logic [7:0] exp);
        @(negedge clk);
        otpRdAddr = a;
        cyc(3);
        note(otpRdData, exp);
    endtask
    // pin change plus time for the synchroniser
    task pin(input logic v);
        @(negedge clk);
        wpN = v;
        cyc(6);
    endtask
    task stop_test();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h212F6FDD;
        mismatches = 0;
        tests_run = 0;
        reset_n = 1'b0;
        wpN = 1'b1;
        otpRdAddr = 7'h00;
        cyc(16);
        reset_n = 1'b1;
        cyc(4);
        st(statusByte[otp_pkg::ST_LOCK], 1'b0);
        st(statusByte[otp_pkg::ST_WP_PIN], 1'b1);
        write_enable_latch();
        st(statusByte[otp_pkg::ST_WEL], 1'b1);
        $display("test write enable done");
        // pin deasserted: lock settable, protect still free
        wrst(8'hFF);
        note(statusByte & 8'hCC, 8'h84);
        st(hwLocked, 1'b0);
        wrst(8'h80);
        note(statusByte & 8'h84, 8'h80);
        $display("test unlocked writes done");
        pin(1'b0);
        st(hwLocked, 1'b1);
        wrst(8'h04);
        note(statusByte & 8'h84, 8'h80);
        // pin released first, then lock cleared
        pin(1'b1);
        st(hwLocked, 1'b0);
        wrst(8'h04);
        note(statusByte & 8'h84, 8'h04);
        pin(1'b0);
        wrst(8'h80);
        note(statusByte & 8'h84, 8'h80);
        st(hwLocked, 1'b1);
        // write disable drops a freshly set latch
        write_enable_latch();
        q = '{otp_pkg::OP_WRITE_DISABLE};
        frame(8);
        st(statusByte[otp_pkg::ST_WEL], 1'b0);
        $display("test hardware lock done");
        // power cycle is the only way out with the pin asserted
        @(negedge clk);
        reset_n = 1'b0;
        cyc(4);
        reset_n = 1'b1;
        cyc(4);
        note(statusByte & 8'h84, 8'h00);
        write_enable_latch();
        q = '{otp_pkg::OP_PROGRAM_OTP, 8'h00, 8'h00};
        frame(24);
        st(statusByte[otp_pkg::ST_WEL], 1'b0);
        write_enable_latch();
        q = '{otp_pkg::OP_PROGRAM_OTP, 8'h00, 8'h00, 8'h00, 8'h55};
        frame(35);
        st(statusByte[otp_pkg::ST_WEL], 1'b0);
        st(userProgrammed, 1'b0);
        $display("test aborted program done");
        // 66 bytes from 3Eh, high address bits set as junk
        write_enable_latch();
        q = '{otp_pkg::OP_PROGRAM_OTP, 8'hFF, 8'hFF, 8'hFE};
        foreach (dat[i]) begin
            dat[i] = 8'($random(seed));
            q.push_back(dat[i]);
        end
        frame(8 * 70);
        st(statusByte[otp_pkg::ST_BUSY], 1'b1);
        st(statusByte[otp_pkg::ST_WEL], 1'b0);
        st(userProgrammed, 1'b1);
        n = 0;
        while (statusByte[otp_pkg::ST_BUSY] !== 1'b0 && n < 400) begin
            cyc(1);
            n++;
        end
        st(statusByte[otp_pkg::ST_BUSY], 1'b0);
        st(statusByte[otp_pkg::ST_ERROR], 1'b0);
        for (int i = 2; i < 66; i++) begin
            rd(7'((62 + i) % 64), dat[i]);
        end
        rd(7'h45, FID[5 * 8 +: 8]);
        $display("test program done");
        write_enable_latch();
        q = '{otp_pkg::OP_PROGRAM_OTP, 8'h00, 8'h00, 8'h00, ~dat[2]};
        frame(40);
        st(statusByte[otp_pkg::ST_BUSY], 1'b0);
        st(statusByte[otp_pkg::ST_WEL], 1'b0);
        rd(7'h00, dat[2]);
        $display("test reprogram refused done");
        stop_test();
    end

    // watchdog, well beyond the expected run length
    initial begin
        #1000000;
        mismatches++;
        stop_test();
    end
endmodule
